// ---- common/dcg_pkg.sv ----
// package: register map, field layout and reset values for the dac clear / gpio share block
package dcg_pkg;
    localparam int DCG_CHANNELS = 12;
    localparam int DCG_CODE_W   = 12;
    localparam int DCG_GP_W     = 8;
    localparam int DCG_ADDR_W   = 6;

    // register word offsets (index); byte address is index * 4
    localparam logic [5:0] DCG_IDX_DATA0   = 6'h00;  // channel data 0..11 at 0x00..0x0b
    localparam logic [5:0] DCG_IDX_CODE0   = 6'h10;  // clear codes 0..11 at 0x10..0x1b
    localparam logic [5:0] DCG_IDX_LATCH0  = 6'h20;  // latch readback 0..11 at 0x20..0x2b
    localparam logic [5:0] DCG_IDX_SYNC    = 6'h30;  // sync load select bits
    localparam logic [5:0] DCG_IDX_LOAD    = 6'h31;  // write: load the latches whose sync select bit is set
    localparam logic [5:0] DCG_IDX_GROUP   = 6'h32;  // clear group 0 membership
    localparam logic [5:0] DCG_IDX_SENSE   = 6'h33;  // sensor enables
    localparam logic [5:0] DCG_IDX_GP_OUT  = 6'h34;  // gp output (0 pulls low)
    localparam logic [5:0] DCG_IDX_GP_IN   = 6'h35;  // gp input readback
    localparam logic [5:0] DCG_IDX_STATUS  = 6'h36;  // clear state status

    localparam int DCG_SENSE_S1_BIT = 0;
    localparam int DCG_SENSE_S2_BIT = 1;
    localparam int DCG_GP_S1N_LINE  = 4;
    localparam int DCG_GP_S2N_LINE  = 6;
    localparam int DCG_GP_S2P_LINE  = 7;

    localparam logic [11:0] DCG_RST_CODE  = 12'h000;
    localparam logic [11:0] DCG_RST_DATA  = 12'h000;
    localparam logic [11:0] DCG_RST_SYNC  = 12'h000;
    localparam logic [11:0] DCG_RST_GROUP = 12'hfff;
    localparam logic [7:0]  DCG_RST_GP    = 8'hff;
    localparam logic [1:0]  DCG_RST_SENSE = 2'h0;

    typedef struct packed {
        logic [DCG_ADDR_W-1:0] addr;
        logic [31:0]           wdata;
        logic                  wr;
        logic                  rd;
    } dcg_bus_req_t;
endpackage : dcg_pkg

// ---- rtl/dcg_top.sv ----
// dac clear group zero control and sensor / gp pin sharing
`timescale 1ns/1ps
`default_nettype none
module dcg_top
    import dcg_pkg::*;
#(
    parameter int CHANNELS = DCG_CHANNELS
) (
    input  wire logic                            REF_CLK,      // 125 MHz clock
    input  wire logic                            RST_N,        // sync reset, active low
    input  wire logic [DCG_ADDR_W-1:0]           ADDR,         // register word index
    input  wire logic [31:0]                     WDATA,        // write data
    input  wire logic                            WR,           // write strobe
    input  wire logic                            RD,           // read strobe
    output logic      [31:0]                     RDATA,        // read data, cycle after RD
    input  wire logic                            CONVERTER_CLEAR_GROUP0_N, // clear pin
    output logic      [CHANNELS*DCG_CODE_W-1:0]  LATCH_OUT,    // latch codes to converters
    input  wire logic [DCG_GP_W-1:0]             GP_IN,        // gp pin levels
    output logic      [DCG_GP_W-1:0]             GP_OUT,       // gp drive value, always 0
    output logic      [DCG_GP_W-1:0]             GP_OE,        // gp pull-low enable
    output logic                                 SENSOR1_NEG_OR_GP4_SENSE, // pin to sensor1
    output logic                                 SENSOR2_NEG_OR_GP6_SENSE, // pin to sensor2
    output logic                                 SENSOR2_POS_OR_GP7_SENSE  // pin to sensor2
);
    // 12-bit reset words for group membership and sync select hold at most 12 channels
    if (CHANNELS < 1 || CHANNELS > DCG_CHANNELS) begin : g_bad_channels
        $error("dcg_top: CHANNELS out of range");
    end

    dcg_bus_req_t req;
    assign req = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

    // clear tracker: held means the synced pin was low at the last edge
    typedef enum logic [1:0] {
        CLR_NORMAL = 2'b01,
        CLR_HELD   = 2'b10
    } dcg_clr_state_t;

    logic [DCG_CODE_W-1:0] data_reg  [CHANNELS];
    logic [DCG_CODE_W-1:0] clr_code  [CHANNELS];
    logic [DCG_CODE_W-1:0] latch     [CHANNELS];
    logic [CHANNELS-1:0]   sync_sel;
    logic [CHANNELS-1:0]   group;
    logic [1:0]            sense_en;
    logic [DCG_GP_W-1:0]   gp_out;
    // pin synchronisers and clear tracker
    logic                  clr_meta;
    logic                  clr_sync;
    logic [DCG_GP_W-1:0]   gp_meta;
    logic [DCG_GP_W-1:0]   gp_sync;
    dcg_clr_state_t        clr_state;
    dcg_clr_state_t        next_clr_state;

    // two-stage synchronisers
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            clr_meta <= 1'b1;
            clr_sync <= 1'b1;
            clr_state <= CLR_NORMAL;
            gp_meta  <= '1;
            gp_sync  <= '1;
        end else begin
            clr_meta <= CONVERTER_CLEAR_GROUP0_N;
            clr_sync <= clr_meta;
            clr_state <= next_clr_state;
            gp_meta  <= GP_IN;
            gp_sync  <= gp_meta;
        end
    end

    // next clear tracker state
    always_comb begin
        next_clr_state = clr_state;
        unique case (clr_state)
            CLR_NORMAL: begin
                if (!clr_sync) next_clr_state = CLR_HELD;
            end
            CLR_HELD: begin
                if (clr_sync) next_clr_state = CLR_NORMAL;
            end
            default: next_clr_state = CLR_NORMAL;
        endcase
    end

    // release is the first cycle the synced pin is high again
    wire clearing   = !clr_sync;
    wire release_ev = (clr_state == CLR_HELD) && clr_sync;
    wire load_all   = req.wr && (req.addr == DCG_IDX_LOAD);
    // register write decode
    wire wr_sync    = req.wr && (req.addr == DCG_IDX_SYNC);
    wire wr_group   = req.wr && (req.addr == DCG_IDX_GROUP);
    wire wr_sense   = req.wr && (req.addr == DCG_IDX_SENSE);
    wire wr_gp_out  = req.wr && (req.addr == DCG_IDX_GP_OUT);

    function automatic logic hit(input logic [5:0] a, input logic [5:0] base, input int ch);
        return a == (base + 6'(ch));
    endfunction : hit

    // low bits of a bus word as a converter code
    function automatic logic [DCG_CODE_W-1:0] code_of(input logic [31:0] w);
        return w[DCG_CODE_W-1:0];
    endfunction : code_of

    for (genvar c = 0; c < CHANNELS; c++) begin : g_ch
        // per channel data register, clear code and output latch
        wire wr_data  = req.wr && hit(req.addr, DCG_IDX_DATA0, c);
        wire wr_code  = req.wr && hit(req.addr, DCG_IDX_CODE0, c);
        wire in_clear = clearing && group[c];
        wire reload   = release_ev && group[c];
        wire direct   = wr_data && !sync_sel[c];
        wire deferred = load_all && sync_sel[c];
        logic [DCG_CODE_W-1:0] next_data;
        logic [DCG_CODE_W-1:0] next_code;
        logic [DCG_CODE_W-1:0] next_latch;
        // only a host write changes the data register, clear or not
        assign next_data = wr_data ? code_of(req.wdata) : data_reg[c];
        assign next_code = wr_code ? code_of(req.wdata) : clr_code[c];
        // clear wins over every load; release ignores the sync select bit
        always_comb begin
            next_latch = latch[c];
            if (in_clear) begin
                next_latch = clr_code[c];
            end else if (reload) begin
                next_latch = data_reg[c];
            end else if (direct) begin
                next_latch = code_of(req.wdata);
            end else if (deferred) begin
                next_latch = data_reg[c];
            end
        end

        always_ff @(posedge REF_CLK) begin
            if (!RST_N) begin
                data_reg[c] <= DCG_RST_DATA;
                clr_code[c] <= DCG_RST_CODE;
                latch[c]    <= DCG_RST_DATA;
            end else begin
                data_reg[c] <= next_data;
                clr_code[c] <= next_code;
                latch[c]    <= next_latch;
            end
        end
        assign LATCH_OUT[c*DCG_CODE_W +: DCG_CODE_W] = latch[c];
    end

    // configuration registers, each written as a whole word
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            sync_sel <= DCG_RST_SYNC[CHANNELS-1:0];
            group    <= DCG_RST_GROUP[CHANNELS-1:0];
            sense_en <= DCG_RST_SENSE;
            gp_out   <= DCG_RST_GP;
        end else begin
            if (wr_sync)   sync_sel <= req.wdata[CHANNELS-1:0];
            if (wr_group)  group    <= req.wdata[CHANNELS-1:0];
            if (wr_sense)  sense_en <= req.wdata[1:0];
            if (wr_gp_out) gp_out   <= req.wdata[DCG_GP_W-1:0];
        end
    end

    // shared pins: sensor use takes the pin off the gp driver
    wire s1 = sense_en[DCG_SENSE_S1_BIT];
    wire s2 = sense_en[DCG_SENSE_S2_BIT];
    // a gp line is usable only while its sensor is off
    logic [DCG_GP_W-1:0] gp_owned;
    always_comb begin
        gp_owned = '1;
        gp_owned[DCG_GP_S1N_LINE] = !s1;
        gp_owned[DCG_GP_S2N_LINE] = !s2;
        gp_owned[DCG_GP_S2P_LINE] = !s2;
    end
    // open drain: never driven high, external pull-up sets the high level
    assign GP_OUT = '0;
    assign GP_OE  = gp_owned & ~gp_out;
    assign SENSOR1_NEG_OR_GP4_SENSE = s1;
    assign SENSOR2_NEG_OR_GP6_SENSE = s2;
    assign SENSOR2_POS_OR_GP7_SENSE = s2;

    // read path
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = '0;
        for (int c = 0; c < CHANNELS; c++) begin
            if (hit(req.addr, DCG_IDX_DATA0, c))  rd_mux = 32'(data_reg[c]);
            if (hit(req.addr, DCG_IDX_CODE0, c))  rd_mux = 32'(clr_code[c]);
            if (hit(req.addr, DCG_IDX_LATCH0, c)) rd_mux = 32'(latch[c]);
        end
        unique case (req.addr)
            DCG_IDX_SYNC:   rd_mux = 32'(sync_sel);
            DCG_IDX_GROUP:  rd_mux = 32'(group);
            DCG_IDX_SENSE:  rd_mux = 32'(sense_en);
            DCG_IDX_GP_OUT: rd_mux = 32'(gp_out);
            DCG_IDX_GP_IN:  rd_mux = 32'(gp_sync);
            DCG_IDX_STATUS: rd_mux = 32'(clearing);
            default: ;
        endcase
    end

    // read data stand one cycle only, zero otherwise
    logic [31:0] next_rdata;
    assign next_rdata = req.rd ? rd_mux : '0;
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            RDATA <= '0;
        end else begin
            RDATA <= next_rdata;
        end
    end
endmodule : dcg_top
`default_nettype wire

// ---- bench/dcg_top_sva.sv ----
// port assertions for the dac clear and gp share block
`timescale 1ns/1ps
`default_nettype none
module dcg_top_sva import dcg_pkg::*; #(parameter int CHANNELS = DCG_CHANNELS) (
    input wire logic REF_CLK,                  // clock
    input wire logic RST_N,                    // sync reset
    input wire logic WR,                       // write strobe
    input wire logic RD,                       // read strobe
    input wire logic [31:0] RDATA,             // read data
    input wire logic CONVERTER_CLEAR_GROUP0_N, // clear pin
    input wire logic [CHANNELS*DCG_CODE_W-1:0] LATCH_OUT, // latch codes
    input wire logic [DCG_GP_W-1:0] GP_OUT,    // gp drive value
    input wire logic [DCG_GP_W-1:0] GP_OE,     // gp pull-low enables
    input wire logic SENSOR1_NEG_OR_GP4_SENSE, // sensor1 pin
    input wire logic SENSOR2_NEG_OR_GP6_SENSE, // sensor2 pin
    input wire logic SENSOR2_POS_OR_GP7_SENSE  // sensor2 pin
);
    wire logic clr_n = CONVERTER_CLEAR_GROUP0_N;
    wire logic s2 = SENSOR2_NEG_OR_GP6_SENSE;
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);
    a_gp_no_high: assert property (GP_OUT == '0) else $error("gp driven high");
    a_rdata_idle: assert property (!$past(RD) |-> RDATA == '0) else $error("rdata unasked");
    a_clear_hold: assert property ((!clr_n && !WR)[*6] |-> $stable(LATCH_OUT))
        else $error("clr moved");
    a_normal_quiet: assert property ((clr_n && !WR)[*7] |-> $stable(LATCH_OUT))
        else $error("latch moved with no load");
    a_s2_pair: assert property (s2 == SENSOR2_POS_OR_GP7_SENSE) else $error("s2 split");
    a_s2_no_gp: assert property (s2 |-> GP_OE[7:6] == 2'b00) else $error("s2 pin driven");
    a_s1_no_gp: assert property (SENSOR1_NEG_OR_GP4_SENSE |-> !GP_OE[DCG_GP_S1N_LINE])
        else $error("s1 pin driven");
    a_reset_vals: assert property (disable iff (1'b0) !RST_N |=> LATCH_OUT == '0 && GP_OE == '0)
        else $error("reset values wrong");
    a_cfg_steady: assert property (!$past(WR) |-> $stable({GP_OE, s2}))
        else $error("pin setup moved");
endmodule : dcg_top_sva
`default_nettype wire

// ---- bench/dcg_pin_model.sv ----
// board pull-ups on the open-drain gp pins
`timescale 1ns/1ps
`default_nettype none
module dcg_pin_model (
    input  wire logic [7:0] oe,  // pull-low enables
    output logic      [7:0] lvl  // pin levels
);
    assign lvl = ~oe;
endmodule : dcg_pin_model
`default_nettype wire

// ---- bench/tb_dcg_top.sv ----
// self-checking bench for the dac clear and gp share block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin failures++; \
    $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb_dcg_top import dcg_pkg::*;;
    logic clk = 0, rst_n = 0, wr = 0, rd = 0, clr_n = 1;
    logic [5:0] addr = '0;
    logic [31:0] wdata = '0, r = 32'he73c;
    logic [11:0] dat[12], cod[12];
    logic [7:0] eo;
    wire logic [31:0] rdata;
    wire logic [143:0] latch;
    wire logic [7:0] gp_in, gp_out, gp_oe;
    wire logic s1, s2n, s2p;
    int failures = 0, tests_run = 0;
    always #4 clk = ~clk;
    dcg_top dut (.REF_CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .CONVERTER_CLEAR_GROUP0_N(clr_n), .LATCH_OUT(latch), .GP_IN(gp_in),
        .GP_OUT(gp_out), .GP_OE(gp_oe), .SENSOR1_NEG_OR_GP4_SENSE(s1),
        .SENSOR2_NEG_OR_GP6_SENSE(s2n), .SENSOR2_POS_OR_GP7_SENSE(s2p));
    dcg_pin_model pins (.oe(gp_oe), .lvl(gp_in));
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : nxt
    task automatic wrt(input logic [5:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wrt
    task automatic rdc(input logic [5:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 `CHK("rdata", e, rdata)
    endtask : rdc
    function automatic logic [11:0] exp_lat(input int c, input logic clr);
        return (clr && c != 11) ? cod[c] : dat[c];
    endfunction : exp_lat
    task automatic chk_l(input logic clr);
        repeat (6) @(posedge clk);
        #1;
        for (int c = 0; c < 12; c++)
            `CHK("latch", exp_lat(c, clr), latch[c*12 +: 12])
    endtask : chk_l
    task automatic stop_test;
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : stop_test
    initial begin
        #100_000;
        failures++;
        stop_test();
    end
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        rdc(DCG_IDX_GROUP, 32'h0000_0fff);
        rdc(DCG_IDX_GP_OUT, 32'h0000_00ff);
        rdc(6'h3f, 32'h0000_0000);
        for (int c = 0; c < 12; c++) begin
            r = nxt(r);
            dat[c] = r[11:0];
            cod[c] = r[27:16];
            wrt(DCG_IDX_DATA0 + 6'(c), {20'h0_0000, dat[c]});
            wrt(DCG_IDX_CODE0 + 6'(c), {20'h0_0000, cod[c]});
        end
        chk_l(1'b0);
        wrt(DCG_IDX_SYNC, 32'h0000_0fff);
        wrt(DCG_IDX_DATA0, 32'h0000_0a5a);
        chk_l(1'b0);
        dat[0] = 12'ha5a;
        wrt(DCG_IDX_LOAD, 32'h0000_0000);
        chk_l(1'b0);
        $display("test load done");
        wrt(DCG_IDX_GROUP, 32'h0000_07ff);
        clr_n <= 1'b0;
        chk_l(1'b1);
        rdc(DCG_IDX_STATUS, 32'h0000_0001);
        dat[3] = 12'h3c3;
        wrt(DCG_IDX_DATA0 + 6'h03, 32'h0000_03c3);
        for (int c = 0; c < 12; c++) rdc(DCG_IDX_DATA0 + 6'(c), {20'h0_0000, dat[c]});
        chk_l(1'b1);
        rdc(DCG_IDX_LATCH0 + 6'h03, {20'h0_0000, cod[3]});
        rdc(DCG_IDX_CODE0 + 6'h05, {20'h0_0000, cod[5]});
        rdc(DCG_IDX_LATCH0 + 6'h0b, {20'h0_0000, dat[11]});
        clr_n <= 1'b1;
        chk_l(1'b0);
        $display("test clear done");
        wrt(DCG_IDX_GP_OUT, 32'h0000_0000);
        for (int m = 0; m < 4; m++) begin
            wrt(DCG_IDX_SENSE, 32'(m));
            repeat (3) @(posedge clk);
            eo = {{2{~m[1]}}, 1'b1, ~m[0], 4'hf};
            `CHK("sense", {m[0], m[1], m[1]}, {s1, s2n, s2p})
            `CHK("gp_oe", eo, gp_oe)
            rdc(DCG_IDX_GP_IN, {24'h00_0000, ~eo});
        end
        wrt(DCG_IDX_SENSE, 32'h0000_0000);
        r = nxt(r);
        wrt(DCG_IDX_GP_OUT, {24'h00_0000, r[7:0]});
        #1;
        `CHK("gp_oe", ~r[7:0], gp_oe)
        $display("test pins done");
        stop_test();
    end
endmodule : tb_dcg_top
bind dcg_top dcg_top_sva #(.CHANNELS(CHANNELS)) u_sva (.REF_CLK(REF_CLK), .RST_N(RST_N),
    .WR(WR), .RD(RD), .RDATA(RDATA), .CONVERTER_CLEAR_GROUP0_N(CONVERTER_CLEAR_GROUP0_N),
    .LATCH_OUT(LATCH_OUT), .GP_OUT(GP_OUT), .GP_OE(GP_OE),
    .SENSOR1_NEG_OR_GP4_SENSE(SENSOR1_NEG_OR_GP4_SENSE),
    .SENSOR2_NEG_OR_GP6_SENSE(SENSOR2_NEG_OR_GP6_SENSE),
    .SENSOR2_POS_OR_GP7_SENSE(SENSOR2_POS_OR_GP7_SENSE));
`default_nettype wire
